// ---- inc/wake_irq_consts.vh ----
// Function
// - six wake polarity bits, reset zero
// - polarity 0 falling edge, 1 rising edge
// - wake5 polarity also sets adc trigger edge
// - edge select bits 7,6 read one, unwritable
// - enable bit 7 gates direct transition
// - enable bit 6 gates timer overflow
// - enable bit 5 gates all wake pins
// - enable bit 4 reads one, writes ignored
// - enable bits 3..0 gate external pins
// - colliding clear while unmasked still yields the exception
// - edge sets flag, software writes zero
// - cpu mask holds requests pending
`ifndef WAKE_IRQ_CONSTS_VH
`define WAKE_IRQ_CONSTS_VH

// register byte offsets
`define OFS_EDGE_SEL    8'h00
`define OFS_INT_EN      8'h04
`define OFS_WAKE_FLAG   8'h08
`define OFS_INT_FLAG    8'h0C
`define OFS_EVT_STATUS  8'h10
`define OFS_EVT_MASK    8'h14

// reserved bits read as one, writable masks
`define EDGE_SEL_RSVD   8'hC0
`define EDGE_SEL_WMASK  8'h3F
`define INT_EN_RSVD     8'h10
`define INT_EN_WMASK    8'hEF
`define INT_FLAG_RSVD   8'h30
`define INT_FLAG_WMASK  8'hCF
`define WAKE_FLAG_WMASK 8'h3F

// field positions in enable / flag registers
`define BIT_DT          7
`define BIT_TA          6
`define BIT_WAKE        5
`define BIT_WAKE_ADC    5

// request vector positions
`define REQ_WAKE        4
`define REQ_TA          5
`define REQ_DT          6

// reset values
`define RST_BYTE        8'h00
`define RST_EVT         12'h000

// event status width and synchroniser depth
`define EVT_W           12
`define SYNC_STAGES     2

// axi responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ---- verilog/pin_edge_detect.v ----
`timescale 1ns/1ps
`include "wake_irq_consts.vh"

// synchronise a group of pins and flag the selected edge of each
module pin_edge_detect #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  // raw pins and polarity
  input  wire [WIDTH-1:0] pin_i,
  input  wire [WIDTH-1:0] polarity_i,
  // one-cycle edge pulses
  output wire [WIDTH-1:0] edge_o
);

  reg [WIDTH-1:0] sync_a; // first stage, read only by sync_b
  reg [WIDTH-1:0] sync_b; // second stage, safe to use
  reg [WIDTH-1:0] prev;   // previous settled level

  // two-flop synchroniser plus history
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync_a <= {WIDTH{1'b0}};
      sync_b <= {WIDTH{1'b0}};
      prev   <= {WIDTH{1'b0}};
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  // rising where polarity set, falling otherwise
  assign edge_o = (polarity_i & sync_b & ~prev) | (~polarity_i & ~sync_b & prev);

endmodule // pin_edge_detect

// ---- verilog/wake_irq_edge_enable.v ----
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "wake_irq_consts.vh"

// edge select, enable and flag logic for the external interrupt sources
module wake_irq_edge_enable (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // pins, asynchronous
  input  wire [5:0]  wake_pin_i,
  input  wire [3:0]  ext_int_pin_i,
  // pin function and polarity from neighbouring control
  input  wire [5:0]  wake_pin_int_sel_i,
  input  wire [3:0]  ext_pin_int_sel_i,
  input  wire [3:0]  ext_edge_sel_i,
  // internal events, same clock
  input  wire        direct_transition_i,
  input  wire        timer_overflow_i,
  // cpu side
  input  wire        cpu_int_mask_i,
  input  wire [6:0]  exception_ack_i,
  output wire [6:0]  irq_request_o,
  output wire        exception_req_o,
  // adc trigger and summary interrupt
  output reg         adc_trigger_o,
  output wire        irq_o
);

  // control registers
  reg  [7:0]  wake_edge_select;     // polarity bits 5..0
  reg  [7:0]  interrupt_enable_one; // source enables
  reg  [5:0]  wake_flag;            // wake request flags
  reg  [7:0]  int_flag;             // dt, ta, ext3..0 flags
  reg  [11:0] evt_status;           // sticky events
  reg  [11:0] evt_mask;             // event mask
  reg  [6:0]  hold_req;             // collisions held for the cpu

  // write channel holding
  reg         aw_full;              // address captured
  reg         w_full;               // data captured
  reg  [7:0]  wr_addr;              // captured address
  reg  [7:0]  wr_data;              // low byte of the write data
  reg  [3:0]  wr_mask_hi;           // bits 11..8, only the event mask uses them
  reg         wr_lane0;             // low byte strobe

  // edge pulses
  wire [5:0]  wake_edge;            // selected edge per wake pin
  wire [3:0]  ext_edge;             // selected edge per ext pin
  wire [5:0]  wake_event;           // wake edges on interrupt pins
  wire [3:0]  ext_event;            // ext edges on interrupt pins
  wire [6:0]  src_event;            // per request source
  wire [11:0] evt_now;              // status event vector

  // handshakes
  wire        wr_do;                // both halves present
  wire        rd_take;              // read address taken
  wire        wr_hit_en;            // write hits enable register
  wire        wr_hit_wf;            // write hits wake flags
  wire        wr_hit_if;            // write hits int flags
  wire        rd_hit_st;            // read hits status

  // derived flag/enable views per source
  wire [6:0]  src_flag;
  wire [6:0]  src_en;
  wire [6:0]  next_src_en;
  wire [6:0]  next_src_flag_clr;
  wire [7:0]  next_en_val;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  reg         wr_ok;

  // wake pins use the software polarity bits
  pin_edge_detect #(.WIDTH(6)) u_wake_edge (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (wake_pin_i),
    .polarity_i (wake_edge_select[5:0]),
    .edge_o     (wake_edge)
  );

  // external pins use the polarity handed in from outside
  pin_edge_detect #(.WIDTH(4)) u_ext_edge (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (ext_int_pin_i),
    .polarity_i (ext_edge_sel_i),
    .edge_o     (ext_edge)
  );

  // an edge only counts on a pin set for interrupt input
  assign wake_event = wake_edge & wake_pin_int_sel_i;
  assign ext_event  = ext_edge & ext_pin_int_sel_i;
  assign src_event  = {direct_transition_i, timer_overflow_i, |wake_event, ext_event};
  assign evt_now    = {direct_transition_i, timer_overflow_i, wake_event, ext_event};

  // axi write: address and data accepted in either order
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
  assign wr_do         = aw_full & w_full & ~s_axi_bvalid;
  assign wr_hit_en     = wr_do & wr_lane0 & (wr_addr == `OFS_INT_EN);
  assign wr_hit_wf     = wr_do & wr_lane0 & (wr_addr == `OFS_WAKE_FLAG);
  assign wr_hit_if     = wr_do & wr_lane0 & (wr_addr == `OFS_INT_FLAG);

  // axi read: one outstanding read
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;
  assign rd_hit_st     = rd_take & (s_axi_araddr == `OFS_EVT_STATUS);

  // capture write halves
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      wr_addr  <= `RST_BYTE;
      wr_data  <= `RST_BYTE;
      wr_mask_hi <= 4'h0;
      wr_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full   <= 1'b1;
        wr_data  <= s_axi_wdata[7:0];
        wr_mask_hi <= s_axi_wdata[11:8];
        wr_lane0 <= s_axi_wstrb[0];
      end else if (wr_do) begin
        w_full <= 1'b0;
      end
    end
  end

  // decode for response code
  always @* begin
    case (wr_addr)
      `OFS_EDGE_SEL, `OFS_INT_EN, `OFS_WAKE_FLAG,
      `OFS_INT_FLAG, `OFS_EVT_STATUS, `OFS_EVT_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write response
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // edge select, enables and mask; reserved bits never stored
  assign next_en_val = wr_data & `INT_EN_WMASK;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wake_edge_select     <= `RST_BYTE;
      interrupt_enable_one <= `RST_BYTE;
      evt_mask             <= `RST_EVT;
    end else if (wr_do && wr_lane0) begin
      if (wr_addr == `OFS_EDGE_SEL)
        wake_edge_select <= wr_data & `EDGE_SEL_WMASK;
      if (wr_addr == `OFS_INT_EN)
        interrupt_enable_one <= next_en_val;
      if (wr_addr == `OFS_EVT_MASK)
        // held copy: the master may already have moved wdata on
        evt_mask <= {wr_mask_hi, wr_data} & {12{wr_lane0}};
    end
  end

  // wake and int flags: writing 0 clears, a new edge wins
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wake_flag <= 6'h00;
      int_flag  <= `RST_BYTE;
    end else begin
      wake_flag <= (wr_hit_wf ? (wake_flag & wr_data[5:0]) : wake_flag) | wake_event;
      int_flag  <= ((wr_hit_if ? (int_flag & (wr_data | ~`INT_FLAG_WMASK)) : int_flag)
                   & `INT_FLAG_WMASK)
                   | {direct_transition_i, timer_overflow_i, 2'b00, ext_event};
    end
  end

  // per-source views in request order: ext3..0, wake, ta, dt
  assign src_flag = {int_flag[`BIT_DT], int_flag[`BIT_TA], |wake_flag, int_flag[3:0]};
  assign src_en   = {interrupt_enable_one[`BIT_DT], interrupt_enable_one[`BIT_TA],
                     interrupt_enable_one[`BIT_WAKE], interrupt_enable_one[3:0]};
  assign next_src_en = {next_en_val[`BIT_DT], next_en_val[`BIT_TA],
                        next_en_val[`BIT_WAKE], next_en_val[3:0]};
  // which sources a flag write is trying to clear
  assign next_src_flag_clr = {wr_hit_if & ~wr_data[`BIT_DT], wr_hit_if & ~wr_data[`BIT_TA],
                              wr_hit_wf & ~(&wr_data[5:0]), {4{wr_hit_if}} & ~wr_data[3:0]};

  // a clear meeting an arriving request unmasked keeps that request alive
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_req <= 7'h00;
    end else begin
      hold_req <= (hold_req & ~exception_ack_i)
                  | ({7{~cpu_int_mask_i}} & src_event
                     & (({7{wr_hit_en}} & src_en & ~next_src_en) | next_src_flag_clr));
    end
  end

  // request per source needs flag and enable, or a held collision; wake shares one enable
  assign irq_request_o   = (src_flag & src_en) | hold_req;
  // the cpu mask keeps requests pending, not lost
  assign exception_req_o = (|irq_request_o) & ~cpu_int_mask_i;

  // shared pin: adc trigger follows wake5 polarity, whatever its function
  always @(posedge ref_clk_i) begin
    if (!rst_n_i)
      adc_trigger_o <= 1'b0;
    else
      adc_trigger_o <= wake_edge[`BIT_WAKE_ADC];
  end

  // sticky event status, cleared by reading; a new event wins
  always @(posedge ref_clk_i) begin
    if (!rst_n_i)
      evt_status <= `RST_EVT;
    else
      evt_status <= (rd_hit_st ? `RST_EVT : evt_status) | evt_now;
  end

  assign irq_o = |(evt_status & evt_mask);

  // read mux; reserved bits read as one
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `RESP_OKAY;
    case (s_axi_araddr)
      `OFS_EDGE_SEL:   next_rdata[7:0]  = wake_edge_select | `EDGE_SEL_RSVD;
      `OFS_INT_EN:     next_rdata[7:0]  = interrupt_enable_one | `INT_EN_RSVD;
      `OFS_WAKE_FLAG:  next_rdata[5:0]  = wake_flag;
      `OFS_INT_FLAG:   next_rdata[7:0]  = int_flag | `INT_FLAG_RSVD;
      `OFS_EVT_STATUS: next_rdata[11:0] = evt_status;
      `OFS_EVT_MASK:   next_rdata[11:0] = evt_mask;
      default:         next_rresp       = `RESP_SLVERR;
    endcase
  end

  // read data channel
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // wake_irq_edge_enable

// ---- tb/wake_irq_edge_enable_props.sv ----
`timescale 1ns/1ps
module wake_irq_props (
  // clock and reset
  input wire        ref_clk_i,
  input wire        rst_n_i,
  // bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // cpu side
  input wire        cpu_int_mask_i,
  input wire [6:0]  irq_request_o,
  input wire        exception_req_o,
  input wire        adc_trigger_o
);
  reg [7:0] rd_addr; // address of the read in flight
  reg [7:0] wr_addr; // address of the write in flight
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // remember addresses so answers can be judged by register
  always @(posedge ref_clk_i) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
  end
  a_mask_holds: assert property (cpu_int_mask_i |-> !exception_req_o)
    else $error("request passed while cpu masked");
  a_req_passes: assert property (|irq_request_o && !cpu_int_mask_i |-> exception_req_o)
    else $error("unmasked request not passed");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_edge_rsvd: assert property (s_axi_rvalid && rd_addr == 8'h00 |-> &s_axi_rdata[7:6])
    else $error("edge select reserved bits not one");
  a_enable_rsvd: assert property (s_axi_rvalid && rd_addr == 8'h04 |-> s_axi_rdata[4])
    else $error("enable reserved bit not one");
  a_adc_pulse: assert property (adc_trigger_o |=> !adc_trigger_o)
    else $error("adc trigger longer than a cycle");
  a_unmapped_err: assert property (s_axi_bvalid && wr_addr > 8'h17 |-> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  c_adc: cover property (adc_trigger_o);
  c_exc: cover property (exception_req_o);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // wake_irq_props

bind wake_irq_edge_enable wake_irq_props u_props (.*);

// ---- tb/cpu_model.sv ----
`timescale 1ns/1ps
module cpu_model #(
  parameter DELAY = 2
) (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  // requests in, acknowledge out
  input  wire       exception_req_o,
  input  wire [6:0] irq_request_o,
  output reg  [6:0] exception_ack_i
);
  integer wait_n; // cycles the request has waited
  // service after a delay, acknowledging the lowest pending source
  always @(posedge ref_clk_i) begin
    exception_ack_i <= 7'h00;
    if (!rst_n_i || !exception_req_o) begin
      wait_n <= 0;
    end else if (wait_n == DELAY) begin
      wait_n <= 0;
      exception_ack_i <= irq_request_o & (~irq_request_o + 7'h01);
    end else begin
      wait_n <= wait_n + 1;
    end
  end
endmodule // cpu_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg         ref_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg  [3:0]  s_axi_wstrb = 4'h1;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg  [5:0]  wake_pin_i = 6'h00, wake_pin_int_sel_i = 6'h3F;
  reg  [3:0]  ext_int_pin_i = 4'h0, ext_pin_int_sel_i = 4'hF, ext_edge_sel_i = 4'hF;
  reg         direct_transition_i = 1'b0, timer_overflow_i = 1'b0, cpu_int_mask_i = 1'b0;
  wire [6:0]  exception_ack_i, irq_request_o;
  wire        exception_req_o, adc_trigger_o, irq_o;
  integer     n_errors = 0, n_compared = 0, cyc = 0, adc_n = 0;
  reg  [31:0] d;  // last read data
  reg  [1:0]  rs; // last response code
  wake_irq_edge_enable dut (.*);
  cpu_model #(.DELAY(3)) u_cpu (.*);
  always #4 ref_clk_i = ~ref_clk_i;
  // count trigger pulses; cut a hang short
  always @(posedge ref_clk_i) begin
    if (adc_trigger_o === 1'b1) adc_n <= adc_n + 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  task results;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  // one write; each handshake judged at the rising edge, released there
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge ref_clk_i);
      while (!s_axi_bvalid) begin
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        @(posedge ref_clk_i);
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge ref_clk_i);
      while (!s_axi_rvalid) begin
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        @(posedge ref_clk_i);
      end
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(d, e);
    end
  endtask
  // reset values, reserved bits, unmapped place
  task t_regs;
    begin
      rc(8'h00, 32'h0000_00C0);
      rc(8'h04, 32'h0000_0010);
      wr(8'h00, 32'h0000_00FF);
      rc(8'h00, 32'h0000_00FF);
      wr(8'h00, 32'h0000_0000);
      rc(8'h00, 32'h0000_00C0);
      wr(8'h04, 32'h0000_00EF);
      rc(8'h04, 32'h0000_00FF);
      wr(8'h04, 32'h0000_0000);
      rc(8'h04, 32'h0000_0010);
      wr(8'h40, 32'h0000_00FF);
      chk(rs, 2'b10);
      rd(8'h40);
      chk(rs, 2'b10);
    end
  endtask
  // each wake pin under both polarities; only the chosen edge counts
  task t_wake;
    integer p, k, a0;
    begin
      cpu_int_mask_i <= 1'b1;
      wr(8'h04, 32'h0000_0020);
      for (p = 0; p < 2; p = p + 1) begin
        wr(8'h00, p ? 32'h0000_003F : 32'h0000_0000);
        wake_pin_i <= p ? 6'h00 : 6'h3F;
        repeat (6) @(posedge ref_clk_i);
        wr(8'h08, 32'h0000_0000);
        for (k = 0; k < 6; k = k + 1) begin
          a0 = adc_n;
          wake_pin_i[k] <= p[0];
          repeat (6) @(posedge ref_clk_i);
          rc(8'h08, 32'h1 << k);
          chk(irq_request_o[4], 1'b1);
          chk(adc_n - a0, k == 5);
          wake_pin_i[k] <= ~p[0];
          wr(8'h08, 32'h0000_0000);
          chk(irq_request_o[4], 1'b0);
          repeat (6) @(posedge ref_clk_i);
          rc(8'h08, 32'h0000_0000);
        end
      end
    end
  endtask
  // internal events and external pins: gating, masking, status
  task t_int;
    begin
      cpu_int_mask_i <= 1'b0;
      wr(8'h04, 32'h0000_00CF);
      wr(8'h14, 32'h0000_0C0F);
      @(posedge ref_clk_i);
      direct_transition_i <= 1'b1;
      timer_overflow_i <= 1'b1;
      ext_int_pin_i <= 4'hF;
      @(posedge ref_clk_i);
      direct_transition_i <= 1'b0;
      timer_overflow_i <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      rc(8'h0C, 32'h0000_00FF);
      chk(irq_request_o, 7'h6F);
      chk(exception_req_o, 1'b1);
      chk(irq_o, 1'b1);
      cpu_int_mask_i <= 1'b1;
      @(posedge ref_clk_i);
      #1 chk(exception_req_o, 1'b0);
      wr(8'h04, 32'h0000_0000);
      chk(irq_request_o, 7'h00);
      wr(8'h0C, 32'h0000_0000);
      rc(8'h0C, 32'h0000_0030);
      rc(8'h10, 32'h0000_0FFF);
      chk(irq_o, 1'b0);
      rc(8'h10, 32'h0000_0000);
      wr(8'h14, 32'h0000_0000);
      timer_overflow_i <= 1'b1;
      @(posedge ref_clk_i);
      timer_overflow_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      chk(irq_o, 1'b0);
      rc(8'h10, 32'h0000_0400);
    end
  endtask
  // enable cleared unmasked in the very cycle a timer overflow arrives
  task t_race;
    begin
      wr(8'h0C, 32'h0000_0000);
      cpu_int_mask_i <= 1'b0;
      wr(8'h04, 32'h0000_0040);
      fork
        wr(8'h04, 32'h0000_0000);
        begin
          repeat (2) @(posedge ref_clk_i);
          timer_overflow_i <= 1'b1;
          @(posedge ref_clk_i);
          timer_overflow_i <= 1'b0;
        end
      join
      chk(irq_request_o, 7'h20);
      chk(exception_req_o, 1'b1);
      repeat (8) @(posedge ref_clk_i);
      chk(irq_request_o, 7'h00);
      rc(8'h0C, 32'h0000_0070);
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_wake;
    t_int;
    t_race;
    results;
  end
endmodule // testbench
